// ---- design/csu_lock.sv ----
// How it works
// - flash, otp, shared sram zero/one refused locked
// - password 128 bits, fetched with 16 waits
// - locked: no debug, outside-code, loader reads
// - full unlock needs all 128 key bits match
// - emulator plus guarded access cuts the link
// - low 64 match allows emulation, reads protected
// - low 64 all ones needs no key
// - password at top words; zeros lock forever
// - no hold-in-reset; boot loop used instead
// - wait boot is mode 2, pins 1,0, trst 0
module csu_lock
  import csu_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_acc_valid,
  input wire logic i_acc_rd,
  input wire logic i_acc_dbg,
  input wire logic i_acc_from_secure,
  input wire logic [21:0] i_acc_addr,
  output logic o_acc_grant,
  input wire logic i_key_wr,
  input wire logic [2:0] i_key_idx,
  input wire logic [15:0] i_key_data,
  output logic o_fl_req,
  output logic [21:0] o_fl_addr,
  input wire logic [15:0] i_fl_data,
  input wire logic i_emu_conn,
  input wire logic i_boot_pin_a,
  input wire logic i_boot_pin_b,
  input wire logic i_trst,
  output logic o_emu_cut,
  output logic o_boot_wait,
  output logic [1:0] o_boot_mode,
  output logic o_locked,
  output logic o_emu_unlocked,
  output logic o_pwd_ready
);
  // ************************************************************
  // declarations
  // ************************************************************
  csu_pwd_if pif ();                         // password from the fetch engine
  logic [15:0] key_r [CSU_PWD_WORDS];        // key words
  logic [15:0] key_nxt [CSU_PWD_WORDS];
  logic [127:0] key_flat;                    // key as one vector
  logic [7:0] rd_seen_r, rd_seen_nxt;        // password words read by software
  logic rd_all;                              // every password word read
  logic unl_r, unl_nxt;                      // full unlock
  logic emu_unl_r, emu_unl_nxt;              // emulation unlock
  logic cut_r, cut_nxt;                      // emulation link cut
  logic [3:0] pin_s1_r, pin_s2_r;            // pin synchroniser
  logic [1:0] mode_r, mode_nxt;              // boot mode code
  logic bwait_r, bwait_nxt;                  // wait boot selected
  logic sec_hit, grd_hit, pwd_hit;           // address decode
  logic emu_s;                               // synced emulator present

  // word-by-word equality over the low n words
  function automatic logic csu_match(input logic [127:0] a, input logic [127:0] b,
                                     input int n);
    logic m;
    m = 1'b1;
    for (int i = 0; i < CSU_PWD_WORDS; i++) begin
      if (i < n && a[i*CSU_WORD_W +: CSU_WORD_W] != b[i*CSU_WORD_W +: CSU_WORD_W]) begin
        m = 1'b0;
      end
    end
    csu_match = m;
  endfunction : csu_match

  // ************************************************************
  // password fetch
  // ************************************************************
  csu_pwd_fetch u_fetch (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .pif(pif.eng),
    .o_fl_req(o_fl_req),
    .o_fl_addr(o_fl_addr),
    .i_fl_data(i_fl_data)
  );

  // ************************************************************
  // pin synchroniser
  // ************************************************************
  // first stage feeds only the second
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end else begin
      pin_s1_r <= {i_trst, i_boot_pin_a, i_boot_pin_b, i_emu_conn};  // mode msb is pin a
      pin_s2_r <= pin_s1_r;
    end
  end
  assign emu_s = pin_s2_r[0];

  // ************************************************************
  // decode
  // ************************************************************
  // protected regions and password window
  always_comb begin
    grd_hit = csu_in_range(i_acc_addr, CSU_FLASH_LO, CSU_FLASH_HI) ||
              csu_in_range(i_acc_addr, CSU_OTP_LO, CSU_OTP_HI) ||
              csu_in_range(i_acc_addr, CSU_SRAM0_LO, CSU_SRAM0_HI);
    sec_hit = grd_hit || csu_in_range(i_acc_addr, CSU_SRAM1_LO, CSU_SRAM1_HI);
    pwd_hit = csu_in_range(i_acc_addr, CSU_PWD_LO, CSU_PWD_HI);
  end

  // grant: open space always, secure space when unlocked or own code
  always_comb begin
    o_acc_grant = 1'b0;
    if (i_acc_valid) begin
      if (!sec_hit || unl_r) begin
        o_acc_grant = 1'b1;
      end else if (i_acc_from_secure && !i_acc_dbg) begin
        o_acc_grant = 1'b1;
      end
    end
  end

  // ************************************************************
  // key and unlock
  // ************************************************************
  always_comb begin
    for (int i = 0; i < CSU_PWD_WORDS; i++) begin
      key_flat[i*CSU_WORD_W +: CSU_WORD_W] = key_r[i];
    end
  end
  assign rd_all = &rd_seen_r;

  // next values of key, read tracking and lock state
  always_comb begin
    key_nxt = key_r;
    rd_seen_nxt = rd_seen_r;
    if (i_key_wr) begin
      key_nxt[i_key_idx] = i_key_data;
    end
    if (i_acc_valid && i_acc_rd && pwd_hit) begin
      rd_seen_nxt[i_acc_addr[2:0]] = 1'b1;
    end
    // full unlock: fetched, all read, nonzero password, whole key matches
    unl_nxt = pif.done && rd_all && (pif.pwd != 128'h0) &&
              csu_match(key_flat, pif.pwd, CSU_PWD_WORDS);
    // emulation unlock: low half erased, or low half of the key matches
    emu_unl_nxt = pif.done && rd_all && (pif.pwd != 128'h0) &&
                  ((pif.pwd[CSU_EMU_W-1:0] == {CSU_EMU_W{1'b1}}) ||
                   csu_match(key_flat, pif.pwd, CSU_EMU_W / CSU_WORD_W));
    // guard trips on a guarded access with the emulator present and no emulation unlock
    cut_nxt = cut_r;
    if (!emu_s) begin
      cut_nxt = 1'b0;
    end else if (i_acc_valid && grd_hit && !emu_unl_r) begin
      cut_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < CSU_PWD_WORDS; i++) begin
        key_r[i] <= 16'h0000;
      end
      rd_seen_r <= 8'h00;
      unl_r <= 1'b0;
      emu_unl_r <= 1'b0;
      cut_r <= 1'b0;
    end else begin
      key_r <= key_nxt;
      rd_seen_r <= rd_seen_nxt;
      unl_r <= unl_nxt;
      emu_unl_r <= emu_unl_nxt;
      cut_r <= cut_nxt;
    end
  end

  // ************************************************************
  // boot mode capture
  // ************************************************************
  // no hold-in-reset: the wait boot loop is flagged instead
  always_comb begin
    mode_nxt = pin_s2_r[2:1];
    bwait_nxt = (pin_s2_r[2:1] == CSU_BOOT_WAIT) && !pin_s2_r[3];
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_r <= 2'h0;
      bwait_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      bwait_r <= bwait_nxt;
    end
  end

  assign o_locked = !unl_r;
  assign o_emu_unlocked = emu_unl_r;
  assign o_emu_cut = cut_r;
  assign o_boot_mode = mode_r;
  assign o_boot_wait = bwait_r;
  assign o_pwd_ready = pif.done;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  property p_locked_refuse;
    i_acc_valid && sec_hit && o_locked && (i_acc_dbg || !i_acc_from_secure) |-> !o_acc_grant;
  endproperty
  a_locked_refuse: assert property (p_locked_refuse) else $error("locked access granted");
  property p_dbg_protect;
    o_emu_unlocked && o_locked && i_acc_valid && sec_hit && i_acc_dbg |-> !o_acc_grant;
  endproperty
  a_dbg_protect: assert property (p_dbg_protect) else $error("debug read leaked");
  property p_unlock_needs_reads;
    !o_locked |-> rd_all && o_pwd_ready;
  endproperty
  a_unlock_needs_reads: assert property (p_unlock_needs_reads) else $error("early unlock");
  property p_zero_lock;
    o_pwd_ready && pif.pwd == 128'h0 |=> o_locked && !o_emu_unlocked;
  endproperty
  a_zero_lock: assert property (p_zero_lock) else $error("zero password unlocked");
  property p_full_match;
    o_pwd_ready && rd_all && pif.pwd != 128'h0 && key_flat == pif.pwd |=> !o_locked;
  endproperty
  a_full_match: assert property (p_full_match) else $error("match did not unlock");
  property p_trip;
    emu_s && i_acc_valid && grd_hit && !o_emu_unlocked |=> o_emu_cut;
  endproperty
  a_trip: assert property (p_trip) else $error("guard did not trip");
  property p_erased_low;
    o_pwd_ready && rd_all && pif.pwd[63:0] == 64'hFFFFFFFFFFFFFFFF |=> o_emu_unlocked;
  endproperty
  a_erased_low: assert property (p_erased_low) else $error("erased low half held");
  property p_boot_wait;
    ##1 o_boot_wait == ($past(pin_s2_r[2:1]) == CSU_BOOT_WAIT && !$past(pin_s2_r[3]));
  endproperty
  a_boot_wait: assert property (p_boot_wait) else $error("wait boot decode wrong");
  property p_rd_needed;
    !rd_all |=> !o_emu_unlocked;
  endproperty
  a_rd_needed: assert property (p_rd_needed) else $error("emu unlock without reads");

  c_unlock: cover property ($fell(o_locked));
  c_trip: cover property ($rose(o_emu_cut));
  c_emu_only: cover property (o_emu_unlocked && o_locked);
endmodule : csu_lock

// ---- design/csu_pwd_fetch.sv ----
// ************************************************************
// password fetch engine, fixed wait states
// ************************************************************
module csu_pwd_fetch
  import csu_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  csu_pwd_if.eng pif,
  output logic o_fl_req,
  output logic [21:0] o_fl_addr,
  input wire logic [15:0] i_fl_data
);
  typedef enum logic [1:0] {FETCH, DONE} csu_fst_t;
  csu_fst_t st_r, st_nxt;               // engine state
  logic [2:0] idx_r, idx_nxt;           // word being fetched
  logic [4:0] cnt_r, cnt_nxt;           // wait-state counter
  logic [127:0] pwd_r, pwd_nxt;         // collected password

  // next-state: each word is held for the full wait count, then captured
  always_comb begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    cnt_nxt = cnt_r;
    pwd_nxt = pwd_r;
    case (st_r)
      FETCH: begin
        if (cnt_r == CSU_PWD_WAIT_LAST) begin
          cnt_nxt = 5'h00;
          pwd_nxt[idx_r*CSU_WORD_W +: CSU_WORD_W] = i_fl_data;
          idx_nxt = idx_r + 3'h1;
          if (idx_r == 3'(CSU_PWD_WORDS - 1)) begin
            st_nxt = DONE;
          end
        end else begin
          cnt_nxt = cnt_r + 5'h01;
        end
      end
      DONE: begin
        st_nxt = DONE;
      end
      default: begin
        st_nxt = FETCH;
      end
    endcase
  end

  // registers only
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= FETCH;
      idx_r <= 3'h0;
      cnt_r <= 5'h00;
      pwd_r <= 128'h0;
    end else begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      cnt_r <= cnt_nxt;
      pwd_r <= pwd_nxt;
    end
  end

  assign o_fl_req = (st_r == FETCH);
  assign o_fl_addr = CSU_PWD_LO + {19'h0, idx_r};
  assign pif.done = (st_r == DONE);
  assign pif.pwd = pwd_r;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  property p_fixed_wait;
    $changed(idx_r) |-> $past(cnt_r) == CSU_PWD_WAIT_LAST;
  endproperty
  a_fixed_wait: assert property (p_fixed_wait) else $error("word advanced early");
endmodule : csu_pwd_fetch

// ---- inc/csu_pkg.sv ----
// ************************************************************
// code security unlock constants
// ************************************************************
package csu_pkg;
  // password and key geometry
  localparam int CSU_WORD_W = 16;                 // flash word width
  localparam int CSU_PWD_WORDS = 8;               // words in the password
  localparam int CSU_KEY_W = 128;                 // key and password width
  localparam int CSU_EMU_W = 64;                  // low part used by the emulation guard
  localparam int CSU_ADDR_W = 22;                 // word address width
  // fixed wait states for password fetches, whatever the flash setting
  localparam int CSU_PWD_WAIT = 16;
  localparam logic [4:0] CSU_PWD_WAIT_LAST = 5'(CSU_PWD_WAIT - 1);
  // password location
  localparam logic [21:0] CSU_PWD_LO = 22'h3F7FF8;
  localparam logic [21:0] CSU_PWD_HI = 22'h3F7FFF;
  // protected regions, plain defaults where no address is fixed
  localparam logic [21:0] CSU_FLASH_LO = 22'h3D8000;
  localparam logic [21:0] CSU_FLASH_HI = 22'h3F7FFF;
  localparam logic [21:0] CSU_OTP_LO = 22'h3D7800;
  localparam logic [21:0] CSU_OTP_HI = 22'h3D7BFF;
  localparam logic [21:0] CSU_SRAM0_LO = 22'h008000;
  localparam logic [21:0] CSU_SRAM0_HI = 22'h0087FF;
  localparam logic [21:0] CSU_SRAM1_LO = 22'h008800;
  localparam logic [21:0] CSU_SRAM1_HI = 22'h008BFF;
  // boot mode code of the looping wait option
  localparam logic [1:0] CSU_BOOT_WAIT = 2'h2;

  // inclusive address window test
  function automatic logic csu_in_range(input logic [21:0] a, input logic [21:0] lo,
                                        input logic [21:0] hi);
    csu_in_range = (a >= lo) && (a <= hi);
  endfunction : csu_in_range
endpackage : csu_pkg

// ---- inc/csu_pwd_if.sv ----
// ************************************************************
// password fetch carrier between the lock and the fetch engine
// ************************************************************
interface csu_pwd_if;
  logic done;            // password fully fetched
  logic [127:0] pwd;     // fetched password, word 0 in the low bits
  modport eng (output done, output pwd);
  modport user (input done, input pwd);
endinterface : csu_pwd_if

// ---- test/csu_flash_model.sv ----
// ************************************************************
// flash array model holding the stored password
// ************************************************************
module csu_flash_model (
  input wire logic i_mclk,
  input wire logic i_fl_req,
  input wire logic [21:0] i_fl_addr,
  input wire logic [127:0] i_pwd,
  output logic [15:0] o_fl_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] last_r; // last value put on the data lines
  logic [2:0] idx; // word index inside the password
  // password occupies the top eight words
  assign idx = 3'(i_fl_addr - 22'h3F7FF8);
  // released lines toggle so a stale word never reads as valid
  always_comb begin
    if (i_fl_req && i_fl_addr >= 22'h3F7FF8) begin
      o_fl_data = i_pwd[idx*16 +: 16];
    end else if (i_fl_req) begin
      o_fl_data = 16'h0000; // words below the password stay zero when secured
    end else begin
      o_fl_data = ~last_r;
    end
  end
  // remember the driven value
  always_ff @(posedge i_mclk) begin
    last_r <= o_fl_data;
  end
endmodule : csu_flash_model

// ---- test/tb.sv ----
// ************************************************************
// self-checking bench for the lock
// ************************************************************
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import csu_pkg::*;
  localparam logic [127:0] PW = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  logic i_mclk, i_rst_n, i_acc_valid, i_acc_rd, i_acc_dbg, i_acc_from_secure;
  logic [21:0] i_acc_addr, o_fl_addr;
  logic i_key_wr, o_acc_grant, o_fl_req, i_emu_conn, i_boot_pin_a, i_boot_pin_b, i_trst;
  logic [2:0] i_key_idx;
  logic [15:0] i_key_data, i_fl_data;
  logic o_emu_cut, o_boot_wait, o_locked, o_emu_unlocked, o_pwd_ready;
  logic [1:0] o_boot_mode;
  logic [127:0] pwd; // password held by the flash model
  int errors = 0;
  int checks = 0;
  csu_lock DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_acc_valid(i_acc_valid),
    .i_acc_rd(i_acc_rd), .i_acc_dbg(i_acc_dbg), .i_acc_from_secure(i_acc_from_secure),
    .i_acc_addr(i_acc_addr), .o_acc_grant(o_acc_grant), .i_key_wr(i_key_wr),
    .i_key_idx(i_key_idx), .i_key_data(i_key_data), .o_fl_req(o_fl_req),
    .o_fl_addr(o_fl_addr), .i_fl_data(i_fl_data), .i_emu_conn(i_emu_conn),
    .i_boot_pin_a(i_boot_pin_a), .i_boot_pin_b(i_boot_pin_b), .i_trst(i_trst),
    .o_emu_cut(o_emu_cut), .o_boot_wait(o_boot_wait), .o_boot_mode(o_boot_mode),
    .o_locked(o_locked), .o_emu_unlocked(o_emu_unlocked), .o_pwd_ready(o_pwd_ready));
  csu_flash_model flash (.i_mclk(i_mclk), .i_fl_req(o_fl_req), .i_fl_addr(o_fl_addr),
    .i_pwd(pwd), .o_fl_data(i_fl_data));
  // 100 ns clock
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic report_and_stop();
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask : chk
  // let n edges pass, then look 10 ns after the last one
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #10;
  endtask : step
  task automatic do_reset(input logic [127:0] p);
    @(posedge i_mclk);
    pwd <= p;
    i_rst_n <= 1'b0;
    repeat (20) @(posedge i_mclk);
    i_rst_n <= 1'b1;
  endtask : do_reset
  task automatic wait_ready();
    int n;
    n = 0;
    while (o_pwd_ready !== 1'b1 && n < 300) begin
      @(posedge i_mclk);
      n++;
    end
    if (n >= 300) begin
      errors++;
      report_and_stop();
    end
  endtask : wait_ready
  // one read access, grant judged in the same cycle
  task automatic acc(input logic [21:0] a, input logic dbg, input logic sec, input logic exp);
    @(posedge i_mclk);
    i_acc_valid <= 1'b1;
    i_acc_rd <= 1'b1;
    i_acc_dbg <= dbg;
    i_acc_from_secure <= sec;
    i_acc_addr <= a;
    #10 chk("grant", exp, o_acc_grant);
    @(posedge i_mclk);
    i_acc_valid <= 1'b0;
  endtask : acc
  task automatic key(input int k, input logic [15:0] d);
    @(posedge i_mclk);
    i_key_wr <= 1'b1;
    i_key_idx <= 3'(k);
    i_key_data <= d;
    @(posedge i_mclk);
    i_key_wr <= 1'b0;
  endtask : key
  // dummy reads of password words 0..n-1 from secure code
  task automatic reads(input int n);
    for (int k = 0; k < n; k++) acc(CSU_PWD_LO + 22'(k), 1'b0, 1'b1, 1'b1);
  endtask : reads
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_fetch();
    do_reset(PW);
    #10 chk("locked", 1, o_locked);
    chk("fl_addr", CSU_PWD_LO, o_fl_addr);
    chk("fl_req", 1, o_fl_req);
    step(16);
    chk("fl_addr", CSU_PWD_LO + 22'h1, o_fl_addr);
    step(111);
    chk("ready", 0, o_pwd_ready);
    step(1);
    chk("ready", 1, o_pwd_ready);
    chk("fl_req", 0, o_fl_req);
  endtask : t_fetch
  task automatic t_locked();
    logic [21:0] a [6] = '{CSU_FLASH_LO, CSU_FLASH_HI, CSU_OTP_LO, CSU_OTP_HI,
                           CSU_SRAM0_LO, CSU_SRAM1_HI};
    foreach (a[i]) begin
      acc(a[i], 1'b1, 1'b0, 1'b0);
      acc(a[i], 1'b0, 1'b0, 1'b0);
      acc(a[i], 1'b0, 1'b1, 1'b1);
    end
    acc(CSU_SRAM1_HI + 22'h1, 1'b1, 1'b0, 1'b1);
    acc(CSU_OTP_LO - 22'h1, 1'b1, 1'b0, 1'b1);
    acc(22'h3F7FF0, 1'b0, 1'b1, 1'b1);
  endtask : t_locked
  task automatic t_emu_cut();
    @(posedge i_mclk);
    i_emu_conn <= 1'b1;
    step(4);
    acc(CSU_SRAM1_LO, 1'b0, 1'b1, 1'b1);
    #10 chk("emu_cut", 0, o_emu_cut);
    acc(CSU_SRAM0_LO, 1'b0, 1'b1, 1'b1);
    #10 chk("emu_cut", 1, o_emu_cut);
    @(posedge i_mclk);
    i_emu_conn <= 1'b0;
    step(4);
    chk("emu_cut", 0, o_emu_cut);
  endtask : t_emu_cut
  task automatic t_full();
    do_reset(PW);
    wait_ready();
    for (int k = 0; k < 8; k++) key(k, PW[k*16 +: 16]);
    step(2);
    chk("locked", 1, o_locked);
    reads(7);
    step(2);
    chk("locked", 1, o_locked);
    acc(CSU_PWD_HI, 1'b0, 1'b1, 1'b1);
    step(2);
    chk("locked", 0, o_locked);
    acc(CSU_FLASH_LO, 1'b1, 1'b0, 1'b1);
    key(7, ~PW[127:112]);
    step(2);
    chk("locked", 1, o_locked);
  endtask : t_full
  task automatic t_emu_only();
    do_reset(PW);
    wait_ready();
    reads(8);
    for (int k = 0; k < 4; k++) key(k, PW[k*16 +: 16]);
    step(2);
    chk("emu_unl", 1, o_emu_unlocked);
    chk("locked", 1, o_locked);
    acc(CSU_FLASH_LO, 1'b1, 1'b0, 1'b0);
    @(posedge i_mclk);
    i_emu_conn <= 1'b1;
    step(4);
    acc(CSU_FLASH_LO, 1'b0, 1'b1, 1'b1);
    #10 chk("emu_cut", 0, o_emu_cut);
    @(posedge i_mclk);
    i_emu_conn <= 1'b0;
  endtask : t_emu_only
  task automatic t_pwd_kinds();
    do_reset({PW[127:64], 64'hFFFF_FFFF_FFFF_FFFF});
    wait_ready();
    reads(8);
    step(2);
    chk("emu_unl", 1, o_emu_unlocked);
    chk("locked", 1, o_locked);
    do_reset(128'h0);
    wait_ready();
    reads(8);
    for (int k = 0; k < 8; k++) key(k, 16'h0000);
    step(2);
    chk("locked", 1, o_locked);
    chk("emu_unl", 0, o_emu_unlocked);
  endtask : t_pwd_kinds
  task automatic t_boot();
    for (int m = 0; m < 4; m++) begin
      @(posedge i_mclk);
      i_boot_pin_a <= m[1];
      i_boot_pin_b <= m[0];
      i_trst <= 1'b0;
      step(4);
      chk("boot_mode", m, o_boot_mode);
      chk("boot_wait", m == 2, o_boot_wait);
    end
    @(posedge i_mclk);
    i_trst <= 1'b1;
    step(4);
    chk("boot_wait", 0, o_boot_wait);
  endtask : t_boot
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    i_rst_n = 1'b0;
    i_acc_valid = 1'b0;
    i_acc_rd = 1'b0;
    i_acc_dbg = 1'b0;
    i_acc_from_secure = 1'b0;
    i_acc_addr = 22'h000000;
    i_key_wr = 1'b0;
    i_key_idx = 3'h0;
    i_key_data = 16'h0000;
    i_emu_conn = 1'b0;
    i_boot_pin_a = 1'b0;
    i_boot_pin_b = 1'b0;
    i_trst = 1'b0;
    pwd = PW;
    t_fetch();
    t_locked();
    t_emu_cut();
    t_full();
    t_emu_only();
    t_pwd_kinds();
    t_boot();
    report_and_stop();
  end
endmodule : tb
